// ---- mcl_pkg.sv ----
/*
  Shared constants and state types for the modem-control and
  line-status block. Assumes one 100 MHz clock and a 32-bit AXI4-Lite bus.
*/
`default_nettype none
package mcl_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_MCR   = 6'h04;
  localparam logic [5:0] IDX_LSR   = 6'h05;
  localparam logic [5:0] IDX_MSR   = 6'h06;
  localparam logic [5:0] IDX_CTRL  = 6'h07;
  localparam logic [5:0] IDX_ISTAT = 6'h08;
  localparam logic [5:0] IDX_ICLR  = 6'h09;
  localparam logic [5:0] IDX_IEN   = 6'h0A;
  // modem_control_reg fields
  localparam int MCR_DTR  = 0;
  localparam int MCR_RTS  = 1;
  localparam int MCR_AUX_OUTPUT_ONE = 2;
  localparam int MCR_AUX_OUTPUT_TWO = 3;
  localparam int MCR_LOOP = 4;
  localparam logic [7:0] MCR_RST = 8'h00;
  // line_status_reg fields
  localparam int LSR_DR   = 0;
  localparam int LSR_TX_HOLDING_EMPTY_FLAG = 5;
  localparam int LSR_TX_ALL_EMPTY_FLAG = 6;
  localparam int LSR_FERR = 7;
  localparam logic TX_HOLDING_EMPTY_FLAG_RST = 1'h1;
  localparam logic TX_ALL_EMPTY_FLAG_RST = 1'h1;
  // interrupt status / clear / enable fields
  localparam int IRQ_RLS  = 0;
  localparam int IRQ_TX_HOLDING_EMPTY_FLAG = 1;
  localparam int IRQ_MS   = 2;
  localparam int CTRL_FIFO = 0;
  localparam logic [3:0] PIN_IDLE = 4'hF;
  localparam int RXF_DEPTH = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0]  msync1;
    logic [3:0]  msync2;
    logic [3:0]  msr_prev;
    logic [3:0]  msr_delta;
    logic [7:0]  modem_control;
    logic        fifo_mode;
    logic [2:0]  ien;
    logic [2:0]  istat;
    logic        tx_holding_empty_flag;
    logic        tx_all_empty_flag;
    logic        err_prev;
    logic        dtr_n;
    logic        rts_n;
    logic        aux2_n;
    logic        aw_got;
    logic [5:0]  aw_idx;
    logic        w_got;
    logic [7:0]  wdat;
    logic        w_be;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mcl_top_s;

  localparam mcl_top_s TOP_RST = '{msync1: PIN_IDLE, msync2: PIN_IDLE,
    msr_prev: 4'h0, msr_delta: 4'h0, modem_control: MCR_RST, fifo_mode: 1'h0,
    ien: 3'h0, istat: 3'h0, tx_holding_empty_flag: TX_HOLDING_EMPTY_FLAG_RST, tx_all_empty_flag: TX_ALL_EMPTY_FLAG_RST,
    err_prev: 1'h0, dtr_n: 1'h1, rts_n: 1'h1, aux2_n: 1'h1,
    aw_got: 1'h0, aw_idx: 6'h00, w_got: 1'h0, wdat: 8'h00, w_be: 1'h0,
    bvalid: 1'h0, bresp: 2'h0, rvalid: 1'h0, rdata: 32'h0, rresp: 2'h0};

  typedef struct packed {
    logic [RXF_DEPTH-1:0] err_bits;
    logic [3:0]           wp;
    logic [3:0]           rp;
    logic [4:0]           cnt;
    logic [4:0]           err_cnt;
  } mcl_trk_s;

  localparam mcl_trk_s TRK_RST = '{err_bits: 16'h0000, wp: 4'h0,
    rp: 4'h0, cnt: 5'h00, err_cnt: 5'h00};
endpackage
`default_nettype wire

// ---- mcl_rxerr_if.sv ----
/*
  Link between the block and its receive-error tracker.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface mcl_rxerr_if;
  logic push;
  logic push_err;
  logic pop;
  logic flush;
  logic any_err;
  modport owner (input push, input push_err, input pop, input flush,
                 output any_err);
  modport user  (output push, output push_err, output pop, output flush,
                 input any_err);
endinterface
`default_nettype wire

// ---- mcl_rxerr_track.sv ----
/*
  Tracks the error mark of every entry held in the receive FIFO.
  Assumes push and pop follow the receive FIFO on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mcl_rxerr_track (
  input  wire logic aclk,
  input  wire logic aresetn,
  mcl_rxerr_if.owner rx
);
  mcl_pkg::mcl_trk_s q;
  mcl_pkg::mcl_trk_s d;
  logic              do_push;
  logic              do_pop;

  assign do_push = rx.push && (q.cnt != 5'(mcl_pkg::RXF_DEPTH));
  assign do_pop  = rx.pop && (q.cnt != 5'h00);
  assign rx.any_err = (q.err_cnt != 5'h00);

  always_comb
  begin
    d = q;
    if (rx.flush)
    begin
      d = mcl_pkg::TRK_RST;
    end
    else
    begin
      if (do_push)
      begin
        d.err_bits[q.wp] = rx.push_err;
        d.wp = q.wp + 4'h1;
      end
      if (do_pop)
      begin
        d.rp = q.rp + 4'h1;
      end
      d.cnt = q.cnt + {4'h0, do_push} - {4'h0, do_pop};
      d.err_cnt = q.err_cnt + {4'h0, do_push && rx.push_err}
                - {4'h0, do_pop && q.err_bits[q.rp]};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= mcl_pkg::TRK_RST;
    else
      q <= d;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  err_count_a: assert property ((q.cnt == 5'h00) |-> (q.err_cnt == 5'h00))
    else $error("error count nonzero with empty fifo");
endmodule
`default_nettype wire

// ---- mcl_modem_line.sv ----
/*
  Modem-control outputs, modem status, line status flags and interrupt
  gathering for one serial channel, reached over AXI4-Lite.
  Assumes transmitter and receiver strobes come from the same clock;
  the modem input pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module mcl_modem_line (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_hold_load,
  input  wire logic        tx_hold_to_shift,
  input  wire logic        tx_fifo_empty,
  input  wire logic        tx_shift_busy,
  input  wire logic        rx_push,
  input  wire logic        rx_push_err,
  input  wire logic        rx_pop,
  input  wire logic        rx_data_ready,
  input  wire logic [3:0]  rx_line_err,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ri_n,
  input  wire logic        dcd_n,
  output logic             dtr_n,
  output logic             rts_n,
  output logic             aux_output_two_n,
  output logic             fifo_mode,
  output logic             loopback,
  output logic             irq
);
  mcl_pkg::mcl_top_s q;
  mcl_pkg::mcl_top_s d;
  mcl_rxerr_if       trk ();
  logic              loop_on;
  logic [3:0]        msr_hi;
  logic              fifo_err;
  logic [7:0]        lsr_val;
  logic [7:0]        msr_val;
  logic              wr_fire;
  logic              ar_fire;
  logic [2:0]        ev;
  logic [2:0]        clr;
  logic              err_any;

  function automatic logic reg_known(input logic [5:0] idx);
    reg_known = (idx >= mcl_pkg::IDX_MCR) && (idx <= mcl_pkg::IDX_IEN);
  endfunction

  mcl_rxerr_track u_trk (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rx      (trk.owner)
  );

  assign trk.push     = rx_push;
  assign trk.push_err = rx_push_err;
  assign trk.pop      = rx_pop;
  // flag cannot linger once single-character mode is chosen
  assign trk.flush    = !q.fifo_mode;

  assign loop_on  = q.modem_control[mcl_pkg::MCR_LOOP];
  // status order dcd, ri, dsr, cts
  assign msr_hi = loop_on ? {q.modem_control[mcl_pkg::MCR_AUX_OUTPUT_TWO], q.modem_control[mcl_pkg::MCR_AUX_OUTPUT_ONE],
                             q.modem_control[mcl_pkg::MCR_DTR], q.modem_control[mcl_pkg::MCR_RTS]}
                          : ~q.msync2;
  assign msr_val  = {msr_hi, q.msr_delta};
  assign fifo_err = q.fifo_mode && trk.any_err;
  assign lsr_val  = {fifo_err, q.tx_all_empty_flag, q.tx_holding_empty_flag, rx_line_err, rx_data_ready};
  assign err_any  = |rx_line_err;

  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign wr_fire = q.aw_got && q.w_got;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    d = q;
    ev = 3'h0;
    clr = 3'h0;
    // modem inputs: two-stage synchroniser
    d.msync1 = {dcd_n, ri_n, dsr_n, cts_n};
    d.msync2 = q.msync1;

    // write address and data, taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      d.aw_got = 1'h1;
      d.aw_idx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      d.w_got = 1'h1;
      d.wdat = s_axi_wdata[7:0];
      d.w_be = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      d.bvalid = 1'h0;
    end
    if (wr_fire)
    begin
      d.aw_got = 1'h0;
      d.w_got = 1'h0;
      d.bvalid = 1'h1;
      d.bresp = reg_known(q.aw_idx) ? mcl_pkg::RESP_OKAY
                                    : mcl_pkg::RESP_SLVERR;
      if (q.w_be)
      begin
        unique case (q.aw_idx)
          // aux one bit is only held here, it drives no pin
          mcl_pkg::IDX_MCR:  d.modem_control = q.wdat;
          mcl_pkg::IDX_CTRL: d.fifo_mode = q.wdat[mcl_pkg::CTRL_FIFO];
          mcl_pkg::IDX_ICLR: clr = q.wdat[2:0];
          mcl_pkg::IDX_IEN:  d.ien = q.wdat[2:0];
          // status register writes are accepted and dropped
          mcl_pkg::IDX_LSR:  d.bresp = mcl_pkg::RESP_OKAY;
          default:           d.bresp = d.bresp;
        endcase
      end
    end

    // register reads
    if (s_axi_rvalid && s_axi_rready)
    begin
      d.rvalid = 1'h0;
    end
    if (ar_fire)
    begin
      d.rvalid = 1'h1;
      d.rresp = reg_known(s_axi_araddr[7:2]) ? mcl_pkg::RESP_OKAY
                                             : mcl_pkg::RESP_SLVERR;
      unique case (s_axi_araddr[7:2])
        mcl_pkg::IDX_MCR:   d.rdata = {24'h0, q.modem_control};
        mcl_pkg::IDX_LSR:   d.rdata = {24'h0, lsr_val};
        mcl_pkg::IDX_MSR:   d.rdata = {24'h0, msr_val};
        mcl_pkg::IDX_CTRL:  d.rdata = {31'h0, q.fifo_mode};
        mcl_pkg::IDX_ISTAT: d.rdata = {29'h0, q.istat};
        mcl_pkg::IDX_IEN:   d.rdata = {29'h0, q.ien};
        default:            d.rdata = 32'h0;
      endcase
    end

    // modem status change bits, cleared by reading the status
    d.msr_prev = msr_hi;
    if (ar_fire && (s_axi_araddr[7:2] == mcl_pkg::IDX_MSR))
    begin
      d.msr_delta = 4'h0;
    end
    d.msr_delta = d.msr_delta | (msr_hi ^ q.msr_prev);

    // holding-empty flag
    if (q.fifo_mode)
    begin
      // fifo mode: follows the fifo, cleared at once by a write
      d.tx_holding_empty_flag = tx_fifo_empty && !tx_hold_load;
    end
    else if (tx_hold_load)
    begin
      // load wins over a transfer in the same cycle
      d.tx_holding_empty_flag = 1'h0;
    end
    else if (tx_hold_to_shift)
    begin
      d.tx_holding_empty_flag = 1'h1;
    end
    d.tx_all_empty_flag = d.tx_holding_empty_flag && !tx_shift_busy;

    // events; a set wins over a clear in the same cycle
    d.err_prev = err_any;
    ev[mcl_pkg::IRQ_RLS]  = err_any && !q.err_prev;
    ev[mcl_pkg::IRQ_TX_HOLDING_EMPTY_FLAG] = d.tx_holding_empty_flag && !q.tx_holding_empty_flag;
    ev[mcl_pkg::IRQ_MS]   = |(msr_hi ^ q.msr_prev);
    d.istat = (q.istat & ~clr) | ev;

    // pins forced inactive high during loopback
    d.dtr_n  = loop_on || !q.modem_control[mcl_pkg::MCR_DTR];
    d.rts_n  = loop_on || !q.modem_control[mcl_pkg::MCR_RTS];
    d.aux2_n = loop_on || !q.modem_control[mcl_pkg::MCR_AUX_OUTPUT_TWO];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= mcl_pkg::TOP_RST;
    else
      q <= d;
  end

  assign s_axi_bvalid     = q.bvalid;
  assign s_axi_bresp      = q.bresp;
  assign s_axi_rvalid     = q.rvalid;
  assign s_axi_rdata      = q.rdata;
  assign s_axi_rresp      = q.rresp;
  assign dtr_n            = q.dtr_n;
  assign rts_n            = q.rts_n;
  assign aux_output_two_n = q.aux2_n;
  assign fifo_mode        = q.fifo_mode;
  assign loopback         = loop_on;
  // one level line from enabled sticky bits
  assign irq              = |(q.istat & q.ien);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  aux_two_pin_a: assert property (
    (q.modem_control[mcl_pkg::MCR_AUX_OUTPUT_TWO] && !loop_on) |=> !aux_output_two_n)
    else $error("aux two pin not low with bit set");

  ring_copy_a: assert property (
    loop_on |-> (msr_val[6] == q.modem_control[mcl_pkg::MCR_AUX_OUTPUT_ONE]))
    else $error("ring indicator does not follow aux one");

  rts_pin_a: assert property (
    !q.modem_control[mcl_pkg::MCR_RTS] [*2] |-> rts_n)
    else $error("rts pin low with bit clear");

  dtr_pin_a: assert property (
    (q.modem_control[mcl_pkg::MCR_DTR] && !loop_on) |=> !dtr_n)
    else $error("dtr pin not low with bit set");

  line_err_irq_a: assert property (
    ($rose(err_any) && q.ien[mcl_pkg::IRQ_RLS]
     && $stable(q.ien)) |=> irq)
    else $error("line error did not raise interrupt");

  ferr_zero_a: assert property (
    !q.fifo_mode |-> !lsr_val[mcl_pkg::LSR_FERR])
    else $error("fifo error flag set outside fifo mode");

  ferr_push_a: assert property (
    (q.fifo_mode && rx_push && rx_push_err && !rx_pop)
    ##1 q.fifo_mode |-> lsr_val[mcl_pkg::LSR_FERR])
    else $error("fifo error flag missed an errored entry");

  all_empty_a: assert property (
    tx_shift_busy |=> !q.tx_all_empty_flag)
    else $error("all-empty flag set while shifting");

  tx_holding_empty_flag_set_a: assert property (
    (!q.fifo_mode && tx_hold_to_shift && !tx_hold_load) |=> q.tx_holding_empty_flag)
    else $error("holding-empty not set on transfer");

  tx_holding_empty_flag_clr_a: assert property (
    tx_hold_load |=> !q.tx_holding_empty_flag)
    else $error("holding-empty not cleared on load");

  tx_holding_empty_flag_irq_a: assert property (
    ($rose(q.tx_holding_empty_flag) && q.ien[mcl_pkg::IRQ_TX_HOLDING_EMPTY_FLAG]) |-> irq)
    else $error("holding-empty did not raise interrupt");

  loop_pins_a: assert property (
    loop_on [*2] |-> (dtr_n && rts_n && aux_output_two_n))
    else $error("modem pins not high in loopback");

  // idle levels once the aux two and dtr bits are clear, outside loopback too; rts pin low when set outside loopback
  aux_two_idle_a: assert property (
    !q.modem_control[mcl_pkg::MCR_AUX_OUTPUT_TWO] |=> aux_output_two_n)
    else $error("aux two pin low with bit clear");

  rts_set_a: assert property (
    (q.modem_control[mcl_pkg::MCR_RTS] && !loop_on) |=> !rts_n)
    else $error("rts pin not low with bit set");

  dtr_idle_a: assert property (
    !q.modem_control[mcl_pkg::MCR_DTR] |=> dtr_n)
    else $error("dtr pin low with bit clear");

  line_err_hold_a: assert property (
    (q.istat[mcl_pkg::IRQ_RLS] && !clr[mcl_pkg::IRQ_RLS]) |=> q.istat[mcl_pkg::IRQ_RLS])
    else $error("line status event bit lost");

  tx_holding_empty_flag_fifo_a: assert property (
    (q.fifo_mode && tx_fifo_empty && !tx_hold_load) |=> q.tx_holding_empty_flag)
    else $error("holding-empty not set with fifo empty");

  all_empty_set_a: assert property (
    (q.fifo_mode && tx_fifo_empty && !tx_hold_load && !tx_shift_busy) |=> q.tx_all_empty_flag)
    else $error("all-empty flag not set when idle");

  loop_cov_c: cover property (loop_on ##1 msr_val[6]);
  err_irq_c: cover property ($rose(err_any) ##1 irq);
  tx_holding_empty_flag_cov_c: cover property (tx_hold_load ##[1:20] $rose(q.tx_holding_empty_flag));
  ferr_cov_c: cover property ($rose(lsr_val[mcl_pkg::LSR_FERR]));
endmodule
`default_nettype wire

// ---- mcl_modem_model.sv ----
/*
  Behavioural modem on the far side of the control lines.
  Assumes active-low pins wired as a null modem back to the block.
*/
`timescale 1ns/1ps
`default_nettype none
module mcl_modem_model (
  input  wire logic dtr_n,
  input  wire logic rts_n,
  input  wire logic ring,
  output logic      cts_n,
  output logic      dsr_n,
  output logic      ri_n,
  output logic      dcd_n
);
  // clear to send answers request, carrier and ready follow terminal ready
  assign cts_n = rts_n;
  assign dsr_n = dtr_n;
  assign dcd_n = dtr_n;
  assign ri_n  = ~ring;
endmodule
`default_nettype wire

// ---- mcl_modem_line_test.sv ----
/*
  Self-checking bench: AXI4-Lite tasks and register-level tests.
  Assumes the package, interface, tracker, design and modem model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module mcl_modem_line_test;
  localparam logic [7:0] A_MCR = {mcl_pkg::IDX_MCR, 2'h0};
  localparam logic [7:0] A_LSR = {mcl_pkg::IDX_LSR, 2'h0};
  localparam logic [7:0] A_MSR = {mcl_pkg::IDX_MSR, 2'h0};
  localparam logic [7:0] A_CTL = {mcl_pkg::IDX_CTRL, 2'h0};
  localparam logic [7:0] A_IST = {mcl_pkg::IDX_ISTAT, 2'h0};
  localparam logic [7:0] A_ICL = {mcl_pkg::IDX_ICLR, 2'h0};
  localparam logic [7:0] A_IEN = {mcl_pkg::IDX_IEN, 2'h0};
  logic        aclk, aresetn, ring;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, rx_line_err;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        tx_hold_load, tx_hold_to_shift, tx_fifo_empty, tx_shift_busy;
  logic        rx_push, rx_push_err, rx_pop, rx_data_ready;
  logic        cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, aux_output_two_n;
  logic        fifo_mode, loopback, irq;
  int          n_mismatch, num_checks, b;

  mcl_modem_line u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tx_hold_load(tx_hold_load),
    .tx_hold_to_shift(tx_hold_to_shift), .tx_fifo_empty(tx_fifo_empty),
    .tx_shift_busy(tx_shift_busy), .rx_push(rx_push), .rx_push_err(rx_push_err),
    .rx_pop(rx_pop), .rx_data_ready(rx_data_ready), .rx_line_err(rx_line_err),
    .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .dtr_n(dtr_n),
    .rts_n(rts_n), .aux_output_two_n(aux_output_two_n), .fifo_mode(fifo_mode),
    .loopback(loopback), .irq(irq));

  mcl_modem_model u_modem (
    .dtr_n(dtr_n), .rts_n(rts_n), .ring(ring), .cts_n(cts_n), .dsr_n(dsr_n),
    .ri_n(ri_n), .dcd_n(dcd_n));

  always #5 aclk = ~aclk;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo;
    n_mismatch++;
    $display("ERROR at %0t: no bus response", $time);
    finish_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int   i;
    logic got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 50 && !got; i++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        got = 1'b1;
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
      end
    end
    if (!got)
      tmo();
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m = 32'hFFFFFFFF,
                     input logic [1:0] er = mcl_pkg::RESP_OKAY);
    int   i;
    logic got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 50 && !got; i++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        got = 1'b1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata & m, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
    end
    if (!got)
      tmo();
  endtask

  task automatic pins(input logic [2:0] exp);
    chk({29'h0, dtr_n, rts_n, aux_output_two_n}, {29'h0, exp});
  endtask

  // one-cycle strobes on the transmit and receive side
  task automatic strobe(input logic [4:0] s);
    {tx_hold_load, tx_hold_to_shift, rx_push, rx_push_err, rx_pop} <= s;
    cyc(1);
    {tx_hold_load, tx_hold_to_shift, rx_push, rx_push_err, rx_pop} <= 5'h00;
    cyc(2);
  endtask

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ring = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {tx_hold_load, tx_hold_to_shift, tx_shift_busy, rx_push, rx_push_err} = '0;
    {rx_pop, rx_data_ready} = '0;
    tx_fifo_empty = 1'b1;
    rx_line_err = 4'h0;
    n_mismatch = 0;
    num_checks = 0;
    cyc(5);
    aresetn <= 1'b1;
    pins(3'h7);
    rdc(A_MCR, 32'h00);
    rdc(A_LSR, 32'h60);
    for (b = 0; b < 4; b++)
    begin
      wr(A_MCR, 8'h01 << b, mcl_pkg::RESP_OKAY);
      cyc(2);
      pins({b != 0, b != 1, b != 3});
      rdc(A_MCR, 32'h01 << b);
    end
    $display("test control pins done");
    wr(A_MCR, 8'h03, mcl_pkg::RESP_OKAY);
    cyc(4);
    rdc(A_MSR, 32'hB0, 32'hF0);
    ring <= 1'b1;
    cyc(4);
    rdc(A_MSR, 32'hF0, 32'hF0);
    ring <= 1'b0;
    wr(A_MCR, 8'h1F, mcl_pkg::RESP_OKAY);
    cyc(4);
    pins(3'h7);
    chk({31'h0, loopback}, 32'h1);
    rdc(A_MSR, 32'hF0, 32'hF0);
    wr(A_MCR, 8'h1B, mcl_pkg::RESP_OKAY);
    cyc(4);
    rdc(A_MSR, 32'hB0, 32'hF0);
    wr(A_MCR, 8'h00, mcl_pkg::RESP_OKAY);
    cyc(4);
    rdc(A_IST, 32'h04, 32'h04);
    wr(A_ICL, 8'h07, mcl_pkg::RESP_OKAY);
    $display("test modem and loopback done");
    rx_line_err <= 4'h2;
    cyc(3);
    rdc(A_LSR, 32'h64);
    rdc(A_IST, 32'h01, 32'h01);
    chk({31'h0, irq}, 32'h0);
    wr(A_IEN, 8'h01, mcl_pkg::RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    rx_line_err <= 4'h0;
    wr(A_ICL, 8'h01, mcl_pkg::RESP_OKAY);
    cyc(1);
    chk({31'h0, irq}, 32'h0);
    $display("test line interrupt done");
    wr(A_IEN, 8'h02, mcl_pkg::RESP_OKAY);
    strobe(5'h10);
    rdc(A_LSR, 32'h00);
    tx_shift_busy <= 1'b1;
    strobe(5'h08);
    rdc(A_LSR, 32'h20);
    chk({31'h0, irq}, 32'h1);
    tx_shift_busy <= 1'b0;
    cyc(2);
    rdc(A_LSR, 32'h60);
    strobe(5'h18);
    rdc(A_LSR, 32'h00);
    wr(A_ICL, 8'h02, mcl_pkg::RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    strobe(5'h08);
    chk({31'h0, irq}, 32'h1);
    wr(A_ICL, 8'h02, mcl_pkg::RESP_OKAY);
    $display("test holding flags done");
    wr(A_CTL, 8'h01, mcl_pkg::RESP_OKAY);
    cyc(2);
    chk({31'h0, fifo_mode}, 32'h1);
    rdc(A_LSR, 32'h60);
    tx_fifo_empty <= 1'b0;
    cyc(2);
    rdc(A_LSR, 32'h00);
    tx_fifo_empty <= 1'b1;
    strobe(5'h06);
    rdc(A_LSR, 32'hE0);
    strobe(5'h04);
    strobe(5'h01);
    rdc(A_LSR, 32'h60);
    strobe(5'h06);
    rdc(A_LSR, 32'hE0);
    wr(A_CTL, 8'h00, mcl_pkg::RESP_OKAY);
    cyc(2);
    rdc(A_LSR, 32'h60);
    $display("test fifo flags done");
    rx_data_ready <= 1'b1;
    rdc(8'h00, 32'h0, 32'hFFFFFFFF, mcl_pkg::RESP_SLVERR);
    wr(8'h3C, 8'hFF, mcl_pkg::RESP_SLVERR);
    wr(A_LSR, 8'h00, mcl_pkg::RESP_OKAY);
    rdc(A_LSR, 32'h61);
    rdc(A_MCR, 32'h00);
    $display("test refused access done");
    finish_test();
  end
endmodule
`default_nettype wire
